/* File: rtl/dac_serial_port.sv */
// Serial command port, DAC register file and acquisition control of a 32-channel DAC.
// Assumes the link pins are asynchronous and an APB master on sys_clk.
//
// The APB interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "dac_port_map.svh"

// Contract
// RL1: first two bits select the mode
// RL2: acquire-hold takes 10-bit word, target acquires
// RL3: DAC load takes 24 bits, code loaded
// RL4: master spaces DAC loads 400 ns apart
// RL5: acquire-read acquires, then reads back next frame
// RL6: read-only reads back without acquisition
// RL7: master waits 400 ns before readback frame
// RL8: frame fall resets counter, later edges ignored
// RL9: clock ignored after bit count reached
// RL10: free-running or gated serial clock both work
// RL11: data-out driven on rises, released 14th fall
// RL12: data-in sampled on falls, only in frame
// RL13: master samples readback on falling edges
// RL14: interface select high enables serial port
// RL15: all-channel DAC load fills all 32 registers
// RL16: all-channel acquire-hold acquires all 32 channels
// RL17: offset select targets offset channel
// RL18: master keeps test bit at zero
// RL19: five address bits pick one of 32
// RL20: code written only in DAC load mode
// RL21: hold-off low delays acquisition until rise
// RL22: busy low for the whole acquisition
// RL23: 90 to 200 ns low pulse resets
// RL24: power-on clears every DAC register
// RL25: addressing word bit order fixed
module dac_serial_port
   import dac_port_pkg::*;
#(
   parameter int ALL_ACQ_CYC = `ALL_ACQ_CYC
) (
   input  wire logic        sys_clk,
   input  wire logic        arst_n,
   input  wire logic        syncN,
   input  wire logic        sclk,
   input  wire logic        din,
   output logic             doutO,
   output logic             doutOe,
   input  wire logic        holdOffN,
   input  wire logic        interfaceSelect,
   output logic             busyN,
   input  wire logic [13:0] analogInputCode,
   output logic             analogBypass,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr
);

   // ****************************************
   // Pin synchronisers
   // ****************************************
   logic [4:0] pinRaw;
   logic [4:0] pinSync;
   logic       syncS, sclkS, dinS, holdS, selS;
   logic       syncD_r, sclkD_r, holdD_r;

   assign pinRaw = {syncN, sclk, din, holdOffN, interfaceSelect};

   pin_sync #(.W(5), .RST(5'h13)) u_sync (
      .sys_clk (sys_clk),
      .arst_n  (arst_n),
      .d       (pinRaw),
      .q       (pinSync)
   );

   assign {syncS, sclkS, dinS, holdS, selS} = pinSync;

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         syncD_r <= 1'b1;
         sclkD_r <= 1'b0;
         holdD_r <= 1'b1;
      end else begin
         syncD_r <= syncS;
         sclkD_r <= sclkS;
         holdD_r <= holdS;
      end
   end

   // Edges found by oversampling, so a gated clock is as good as a running one
   logic syncFall, sclkFall, sclkRise, holdRise;
   assign syncFall = syncD_r & ~syncS;
   assign sclkFall = sclkD_r & ~sclkS;   // see RL10
   assign sclkRise = ~sclkD_r & sclkS;
   assign holdRise = ~holdD_r & holdS;

   // ****************************************
   // Hold-off pulse width measurement
   // ****************************************
   logic [5:0] lowCnt_r;
   logic       softReset;

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n)
         lowCnt_r <= 6'h00;
      else if (holdS)
         lowCnt_r <= 6'h00;
      else if (lowCnt_r != 6'h3F)
         lowCnt_r <= lowCnt_r + 6'h01;
   end

   // Short glitches and long hold-offs both pass; only the window resets
   assign softReset = holdRise && (lowCnt_r >= 6'(`RESET_MIN_CYC))
                      && (lowCnt_r <= 6'(`RESET_MAX_CYC));   // see RL23

   // ****************************************
   // APB slave
   // ****************************************
   logic        ctrlEn_r;
   logic [31:0] prdata_r;
   logic        apbSetup, apbWrite, mapped;
   logic [31:0] rdMux;
   port_state_t state_r;
   logic        acqPend_r, acqAct_r, readPend_r;
   logic [5:0]  lastTgt_r;
   port_mode_t  lastMode_r;

   assign apbSetup = psel & ~penable;
   assign apbWrite = psel & penable & pwrite;
   assign mapped   = (paddr == `CTRL_OFS) || (paddr == `STATUS_OFS)
                     || (paddr == `TARGET_OFS);
   assign pready   = 1'b1;
   assign pslverr  = psel & penable & ~mapped;
   assign prdata   = prdata_r;

   assign rdMux = (paddr == `CTRL_OFS)   ? {31'h0, ctrlEn_r} :
                  (paddr == `STATUS_OFS) ? {24'h0, selS, readPend_r, acqPend_r,
                                            acqAct_r, state_r} :
                  (paddr == `TARGET_OFS) ? {22'h0, lastMode_r, 2'h0, lastTgt_r} :
                  32'h0;

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrlEn_r <= `CTRL_RST;
         prdata_r <= 32'h0;
      end else begin
         if (apbSetup)
            prdata_r <= rdMux;
         if (apbWrite && paddr == `CTRL_OFS)
            ctrlEn_r <= pwdata[`CTRL_EN_BIT];
      end
   end

   // ****************************************
   // Serial frame decode
   // ****************************************
   function automatic logic [5:0] target_index(input addr_word_t w);
      // Offset select overrides the channel address
      target_index = w.offsetSel ? `OFFSET_CHAN
                                 : {1'b0, w.channelAddress};   // see RL17, RL19
   endfunction : target_index

   logic [23:0] shift_r;
   logic [4:0]  bitCnt_r;
   port_mode_t  mode_r;
   logic [13:0] outShift_r;
   logic        portOn;
   logic [23:0] shiftNxt;
   logic        inBit, outBit, lastIn, lastOut;
   logic        addrEnd, dacEnd;
   addr_word_t  addrWord, dacWord;
   logic [13:0] dacCode;

   assign portOn   = selS & ctrlEn_r;                   // see RL14
   assign shiftNxt = {shift_r[22:0], dinS};
   assign inBit    = (state_r == ST_IN) & sclkFall;     // see RL12
   assign outBit   = (state_r == ST_OUT) & sclkFall;
   // Mode bits are latched after two bits, so the length is known early
   assign lastIn   = (bitCnt_r == `DAC_LAST_BIT) ||
                     ((bitCnt_r == `ADDR_LAST_BIT) && (mode_r != MODE_DAC_LOAD));
   assign lastOut  = bitCnt_r == `READ_LAST_BIT;
   assign addrEnd  = inBit & lastIn & (mode_r != MODE_DAC_LOAD);   // see RL2
   assign dacEnd   = inBit & lastIn & (mode_r == MODE_DAC_LOAD);   // see RL3
   assign addrWord = addr_word_t'(shiftNxt[9:0]);       // see RL25
   assign dacWord  = addr_word_t'(shiftNxt[23:14]);
   assign dacCode  = shiftNxt[13:0];

   // Counter restarts only from idle or done; mid-frame edges are ignored
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_r  <= ST_IDLE;
         bitCnt_r <= 5'h00;
         shift_r  <= 24'h0;
         mode_r   <= MODE_ACQUIRE_HOLD;
      end else if (softReset) begin
         state_r  <= ST_IDLE;
         bitCnt_r <= 5'h00;
      end else begin
         case (state_r)
            ST_IDLE, ST_DONE: begin
               if (syncFall && portOn) begin                   // see RL8
                  state_r  <= readPend_r ? ST_OUT : ST_IN;
                  bitCnt_r <= 5'h00;
               end
            end
            ST_IN: begin
               if (sclkFall) begin
                  shift_r  <= shiftNxt;
                  bitCnt_r <= bitCnt_r + 5'h01;
                  if (bitCnt_r == `MODE_LAST_BIT)
                     mode_r <= port_mode_t'(shiftNxt[1:0]);    // see RL1
                  if (lastIn)
                     state_r <= ST_DONE;                       // see RL9
               end
            end
            ST_OUT: begin
               if (sclkFall) begin
                  bitCnt_r <= bitCnt_r + 5'h01;
                  if (lastOut)
                     state_r <= ST_DONE;
               end
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // ****************************************
   // Readback shifter
   // ****************************************
   logic [5:0] readIdx_r;
   logic [13:0] dacReg_r [0:`CHAN_COUNT];
   logic       startOut;

   assign startOut = (state_r == ST_IDLE || state_r == ST_DONE) && syncFall
                     && portOn && readPend_r;

   // Data changes on rises so it is steady when the master samples on falls
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         outShift_r <= 14'h0;
         doutO      <= 1'b0;
         doutOe     <= 1'b0;
      end else if (softReset) begin
         doutOe     <= 1'b0;
      end else begin
         if (startOut)
            outShift_r <= dacReg_r[readIdx_r];                 // see RL6
         else if (state_r == ST_OUT && sclkRise) begin
            doutO      <= outShift_r[`CODE_MSB];               // see RL11
            doutOe     <= 1'b1;
            outShift_r <= {outShift_r[12:0], 1'b0};
         end
         if (outBit && lastOut)
            doutOe <= 1'b0;                                    // see RL11
      end
   end

   // ****************************************
   // Acquisition control
   // ****************************************
   logic [13:0] acqCnt_r;
   logic [5:0]  acqTgt_r;
   logic        acqAll_r;
   logic        acqCmd, acqStart, acqDone;
   logic        dacAll;

   // The test bit is not decoded; the master keeps it low
   assign acqCmd   = addrEnd && (mode_r == MODE_ACQUIRE_HOLD
                     || mode_r == MODE_ACQ_READ);              // see RL5, RL18
   assign acqStart = acqPend_r & holdS;                        // see RL21
   assign acqDone  = acqAct_r && (acqCnt_r == 14'h0);
   assign dacAll   = dacEnd & dacWord.allChan;
   assign busyN    = ~acqAct_r;                                // see RL22
   assign analogBypass = acqPend_r | acqAct_r;

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         acqPend_r  <= 1'b0;
         acqAct_r   <= 1'b0;
         acqCnt_r   <= 14'h0;
         acqTgt_r   <= 6'h00;
         acqAll_r   <= 1'b0;
         readPend_r <= 1'b0;
         readIdx_r  <= 6'h00;
         lastTgt_r  <= 6'h00;
         lastMode_r <= MODE_ACQUIRE_HOLD;
      end else if (softReset) begin
         acqPend_r  <= 1'b0;
         acqAct_r   <= 1'b0;
         readPend_r <= 1'b0;
      end else begin
         if (acqCmd) begin
            acqPend_r <= 1'b1;
            acqTgt_r  <= target_index(addrWord);
            acqAll_r  <= addrWord.allChan & (mode_r == MODE_ACQUIRE_HOLD); // see RL16
         end else if (acqStart) begin
            acqPend_r <= 1'b0;
            acqAct_r  <= 1'b1;
            acqCnt_r  <= acqAll_r ? 14'(ALL_ACQ_CYC) : 14'(`ACQ_CYC);
         end else if (acqDone)
            acqAct_r  <= 1'b0;
         else if (acqAct_r)
            acqCnt_r  <= acqCnt_r - 14'h1;
         if (addrEnd && mode_r[1]) begin
            readPend_r <= 1'b1;                                 // see RL5, RL6
            readIdx_r  <= target_index(addrWord);
         end else if (startOut)
            readPend_r <= 1'b0;
         if (addrEnd || dacEnd) begin
            lastMode_r <= mode_r;
            lastTgt_r  <= target_index(addrEnd ? addrWord : dacWord);
         end
      end
   end

   // ****************************************
   // DAC register file
   // ****************************************
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         for (int i = 0; i <= `CHAN_COUNT; i++)
            dacReg_r[i] <= 14'h0;                               // see RL24
      end else if (softReset) begin
         for (int i = 0; i <= `CHAN_COUNT; i++)
            dacReg_r[i] <= 14'h0;                               // see RL23
      end else if (dacAll) begin
         // Test fill: code MSB picks all ones or all zeros
         for (int i = 0; i < `CHAN_COUNT; i++)
            dacReg_r[i] <= {14{dacCode[`CODE_MSB]}};            // see RL15
      end else if (dacEnd) begin
         dacReg_r[target_index(dacWord)] <= dacCode;            // see RL3, RL20
      end else if (acqDone && acqAll_r) begin
         for (int i = 0; i < `CHAN_COUNT; i++)
            dacReg_r[i] <= analogInputCode;                     // see RL16
      end else if (acqDone) begin
         dacReg_r[acqTgt_r] <= analogInputCode;                 // see RL2, RL22
      end
   end

endmodule : dac_serial_port

/* File: rtl/dac_port_map.svh */
// Offsets, field positions, reset values and timing counts of the serial DAC port.
// Assumes a 250 MHz system clock; included by the top module, the checker and the bench.
`ifndef DAC_PORT_MAP_SVH
`define DAC_PORT_MAP_SVH

// ****************************************
// Timing
// ****************************************
`define CLK_PERIOD_NS   4
`define RESET_MIN_NS    90
`define RESET_MAX_NS    200
`define RESET_MIN_CYC   ((`RESET_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESET_MAX_CYC   (`RESET_MAX_NS / `CLK_PERIOD_NS)
`define ACQ_MAX_US      16
`define ACQ_CYC         ((`ACQ_MAX_US * 1000) / `CLK_PERIOD_NS)
`define ALL_ACQ_US      45
`define ALL_ACQ_CYC     ((`ALL_ACQ_US * 1000) / `CLK_PERIOD_NS)

// ****************************************
// Serial framing
// ****************************************
`define MODE_LAST_BIT   5'h01
`define ADDR_LAST_BIT   5'h09
`define DAC_LAST_BIT    5'h17
`define READ_LAST_BIT   5'h0D
`define CHAN_COUNT      32
`define OFFSET_CHAN     6'h20
`define CODE_MSB        13

// ****************************************
// APB register map
// ****************************************
`define CTRL_OFS        8'h00
`define STATUS_OFS      8'h04
`define TARGET_OFS      8'h08
`define CTRL_RST        1'h1
`define CTRL_EN_BIT     0
`define ST_BUSY_BIT     4
`define ST_PEND_BIT     5
`define ST_READ_BIT     6
`define ST_SEL_BIT      7
`define TG_MODE_LSB     8

`endif

/* File: rtl/dac_port_pkg.sv */
// Types of the serial DAC port: modes, port states and the addressing word.
// Assumes nothing beyond the map header.
package dac_port_pkg;

   typedef enum logic [1:0] {
      MODE_ACQUIRE_HOLD = 2'h0,
      MODE_DAC_LOAD     = 2'h1,
      MODE_ACQ_READ     = 2'h2,
      MODE_READ_ONLY    = 2'h3
   } port_mode_t;

   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_IN   = 4'h2,
      ST_OUT  = 4'h4,
      ST_DONE = 4'h8
   } port_state_t;

   typedef struct packed {
      port_mode_t  mode;
      logic        allChan;
      logic        offsetSel;
      logic        testBit;
      logic [4:0]  channelAddress;
   } addr_word_t;

endpackage : dac_port_pkg

/* File: rtl/pin_sync.sv */
// Two-stage synchroniser for pins arriving from outside the system clock.
// Assumes the reset value matches each pin's idle level.
`timescale 1ns/1ps
module pin_sync #(
   parameter int          W   = 1,
   parameter logic [W-1:0] RST = '0
) (
   input  wire logic         sys_clk,
   input  wire logic         arst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_r;

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         meta_r <= RST;
         q      <= RST;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule : pin_sync

/* File: dv/dac_serial_port_sva.sv */
// Checker of the serial DAC port: link pins, acquisition status, APB slave.
// Assumes binding onto dac_serial_port with its parameter handed on.
`timescale 1ns/1ps
`include "dac_port_map.svh"
module dac_serial_port_sva
   import dac_port_pkg::*;
#(
   parameter int ALL_ACQ_CYC = 11250
) (
   input wire logic        sys_clk,
   input wire logic        arst_n,
   input wire logic        syncN,
   input wire logic        sclk,
   input wire logic        doutO,
   input wire logic        doutOe,
   input wire logic        holdOffN,
   input wire logic        busyN,
   input wire logic        analogBypass,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr
);
   // ****
   // Helpers
   // ****
   localparam int BUSY_MAX = (ALL_ACQ_CYC > `ACQ_CYC ? ALL_ACQ_CYC : `ACQ_CYC) + 2;
   logic [15:0] lowCnt_r;
   wire         unmapped = !(paddr inside {`CTRL_OFS, `STATUS_OFS, `TARGET_OFS});
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         lowCnt_r <= 16'h0000;
      end else begin
         lowCnt_r <= busyN ? 16'h0000 : lowCnt_r + 16'h0001;
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   sequence s_acc;
      psel && penable;
   endsequence
   sequence s_outFall;
      doutOe && $fell(sclk);
   endsequence
   // ****
   // Properties
   // ****
   a_apb_ready: assert property (s_acc |-> pready)
      else $error("pready low in access");
   a_err_unmapped: assert property (pslverr == (psel && penable && unmapped))
      else $error("pslverr wrong");
   a_rd_hold: assert property (!(psel && !penable) |=> $stable(prdata))
      else $error("prdata moved outside setup");
   a_dout_frame: assert property ($rose(doutOe) |-> !syncN)
      else $error("dout driven outside frame");
   a_dout_stable: assert property (s_outFall |=> (!doutOe || $stable(doutO))[*4])
      else $error("dout changed after clock fall");
   a_dout_release: assert property ($rose(syncN) |-> !doutOe)
      else $error("dout not released");
   a_busy_stays: assert property ($fell(busyN) |=> !busyN[*8])
      else $error("busy pulse too short");
   a_busy_bound: assert property (lowCnt_r < BUSY_MAX)
      else $error("busy low too long");
   a_bypass_busy: assert property (!busyN |-> analogBypass)
      else $error("bypass off while busy");
   a_hold_start: assert property ($fell(busyN) |-> holdOffN)
      else $error("acquire began in hold-off");
endmodule : dac_serial_port_sva

bind dac_serial_port dac_serial_port_sva #(.ALL_ACQ_CYC(ALL_ACQ_CYC)) u_sva (
   .sys_clk, .arst_n, .syncN, .sclk, .doutO, .doutOe, .holdOffN, .busyN, .analogBypass,
   .psel, .penable, .paddr, .prdata, .pready, .pslverr
);

/* File: dv/serial_master.sv */
// Serial link master model: gated 80 ns clock, MSB-first frames, readback capture.
// Assumes the bench calls xfer and never overlaps two frames.
`timescale 1ns/1ps
module serial_master (
   output logic      syncN,
   output logic      sclk,
   output logic      din,
   input  wire logic doutO,
   input  wire logic doutOe
);
   // ****
   // Frame driver
   // ****
   // Released line shows the inverse, so a late drive or an early release reads wrong
   wire dout = doutOe ? doutO : ~doutO;
   initial begin
      syncN = 1'b1;
      sclk = 1'b0;
      din = 1'b0;
   end
   // Clock stands low between frames; g puts a select glitch in mid-frame
   task automatic xfer(input int n, input logic [29:0] w, input bit g, output logic [13:0] rd);
      rd = 14'h0000;
      #1.3;
      syncN = 1'b0;
      #40;
      for (int i = n - 1; i >= 0; i--) begin
         sclk = 1'b1;
         din = w[i];
         #40;
         sclk = 1'b0;
         rd = {rd[12:0], dout};
         if (g && i == n - 5) begin
            syncN = 1'b1;
            #20;
            syncN = 1'b0;
            #20;
         end else begin
            #40;
         end
      end
      din = ~din;
      syncN = 1'b1;
   endtask : xfer
endmodule : serial_master

/* File: dv/multichannel_dac_serial_port_test.sv */
// Self-checking bench of the serial DAC port: frames, acquisition, soft reset, APB.
// Assumes serial_master drives the link and the checker is bound to the design.
`timescale 1ns/1ps
`include "dac_port_map.svh"
module multichannel_dac_serial_port_test
   import dac_port_pkg::*;
;
   // ****
   // Harness
   // ****
   localparam int ALL_CYC = 20;
   logic        sys_clk = 1'b0;
   logic        arst_n = 1'b0;
   logic        holdOffN = 1'b1;
   logic        interfaceSelect = 1'b1;
   logic [13:0] analogInputCode = 14'h0000;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000;
   wire         syncN, sclk, din, doutO, doutOe, busyN, analogBypass, pready, pslverr;
   wire  [31:0] prdata;
   int          errors = 0;
   int          n_checks = 0;
   int          cyc = 0;
   int          lowCnt = 0;

   dac_serial_port #(.ALL_ACQ_CYC(ALL_CYC)) DUT (.sys_clk, .arst_n, .syncN, .sclk, .din,
      .doutO, .doutOe, .holdOffN, .interfaceSelect, .busyN, .analogInputCode, .analogBypass,
      .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
   serial_master link (.syncN, .sclk, .din, .doutO, .doutOe);

   always #2 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cyc++;
      if (busyN === 1'b0) lowCnt <= lowCnt + 1;
      if (cyc == 50000) begin
         errors++;
         report_and_stop();
      end
   end

   task report_and_stop;
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : report_and_stop

   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      n_checks++;
      if (s !== e) begin
         $display("mismatch %s exp %h got %h", nm, e, s);
         errors++;
      end
   endtask : chk

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   function automatic logic [9:0] aw(port_mode_t m, logic al, logic of, logic [4:0] ch);
      addr_word_t w;
      w = '{mode: m, allChan: al, offsetSel: of, testBit: 1'b0, channelAddress: ch};
      return w;
   endfunction : aw

   task automatic fr(input int n, input logic [29:0] w, input bit g);
      logic [13:0] d;
      link.xfer(n, w, g, d);
      #400;
   endtask : fr

   task automatic rb(input logic [9:0] a, input logic [13:0] e);
      logic [13:0] d;
      fr(10, 30'(a), 0);
      while (busyN !== 1'b1) @(posedge sys_clk);
      link.xfer(14, 30'h2AAAAAAA, 0, d);
      #400;
      chk("readback", 32'(d), 32'(e));
      chk("doutOe", 32'(doutOe), 32'h0);
   endtask : rb

   task automatic pulse(input int c);
      @(posedge sys_clk);
      holdOffN <= 1'b0;
      repeat (c) @(posedge sys_clk);
      holdOffN <= 1'b1;
      repeat (8) @(posedge sys_clk);
   endtask : pulse

   // ****
   // Scenarios
   // ****
   task automatic t_regs;
      logic [31:0] r;
      logic        e;
      apb(1'b0, `CTRL_OFS, 32'h0, r, e);
      chk("ctrl", r, 32'h1);
      apb(1'b0, `STATUS_OFS, 32'h0, r, e);
      chk("status", r, 32'h81);
      apb(1'b0, 8'h0C, 32'h0, r, e);
      chk("unmapped", {r[30:0], e}, 32'h1);
      rb(aw(MODE_READ_ONLY, 0, 0, 5'h1F), 14'h0000);
      $display("t_regs done");
   endtask : t_regs

   task automatic t_load;
      logic [31:0] r;
      logic        e;
      fr(24, {6'h00, aw(MODE_DAC_LOAD, 0, 0, 5'h15), 14'h2A5C}, 0);
      fr(30, {aw(MODE_DAC_LOAD, 0, 0, 5'h0A), 14'h1C3B, 6'h3F}, 1);
      fr(24, {6'h00, aw(MODE_DAC_LOAD, 0, 1, 5'h0A), 14'h0F0F}, 0);
      rb(aw(MODE_READ_ONLY, 0, 0, 5'h15), 14'h2A5C);
      rb(aw(MODE_READ_ONLY, 0, 0, 5'h0A), 14'h1C3B);
      rb(aw(MODE_READ_ONLY, 0, 1, 5'h00), 14'h0F0F);
      apb(1'b0, `TARGET_OFS, 32'h0, r, e);
      chk("target", r, 32'h320);
      $display("t_load done");
   endtask : t_load

   task automatic t_all;
      fr(24, {6'h00, aw(MODE_DAC_LOAD, 1, 0, 5'h00), 14'h2000}, 0);
      rb(aw(MODE_READ_ONLY, 0, 0, 5'h03), 14'h3FFF);
      rb(aw(MODE_READ_ONLY, 0, 1, 5'h00), 14'h0F0F);
      @(posedge sys_clk);
      analogInputCode <= 14'h0555;
      lowCnt = 0;
      fr(10, 30'(aw(MODE_ACQUIRE_HOLD, 1, 0, 5'h00)), 0);
      while (busyN !== 1'b1 || lowCnt == 0) @(posedge sys_clk);
      chk("allLen", 32'(lowCnt), 32'(ALL_CYC + 1));
      rb(aw(MODE_READ_ONLY, 0, 0, 5'h1F), 14'h0555);
      $display("t_all done");
   endtask : t_all

   task automatic t_acq;
      logic [13:0] d;
      @(posedge sys_clk);
      analogInputCode <= 14'h1234;
      holdOffN <= 1'b0;
      lowCnt = 0;
      fr(10, 30'(aw(MODE_ACQUIRE_HOLD, 0, 0, 5'h02)), 0);
      chk("bypass", 32'(analogBypass), 32'h1);
      chk("heldOff", 32'(busyN), 32'h1);
      @(posedge sys_clk);
      holdOffN <= 1'b1;
      while (busyN !== 1'b1 || lowCnt == 0) @(posedge sys_clk);
      chk("acqLen", 32'(lowCnt >= `ACQ_CYC && lowCnt <= `ACQ_CYC + 1), 32'h1);
      chk("bypassOff", 32'(analogBypass), 32'h0);
      fr(24, {6'h00, aw(MODE_READ_ONLY, 0, 0, 5'h02), 14'h3333}, 0);
      link.xfer(14, 30'h0, 0, d);
      #400;
      chk("codeIgnored", 32'(d), 32'h1234);
      @(posedge sys_clk);
      analogInputCode <= 14'h0ABC;
      rb(aw(MODE_ACQ_READ, 0, 0, 5'h09), 14'h0ABC);
      $display("t_acq done");
   endtask : t_acq

   task automatic t_reset;
      pulse(10);
      rb(aw(MODE_READ_ONLY, 0, 0, 5'h1F), 14'h0555);
      pulse(30);
      rb(aw(MODE_READ_ONLY, 0, 0, 5'h1F), 14'h0000);
      rb(aw(MODE_READ_ONLY, 0, 1, 5'h00), 14'h0000);
      $display("t_reset done");
   endtask : t_reset

   task automatic t_off;
      logic [31:0] r;
      logic        e;
      @(posedge sys_clk);
      interfaceSelect <= 1'b0;
      repeat (4) @(posedge sys_clk);
      fr(24, {6'h00, aw(MODE_DAC_LOAD, 0, 0, 5'h06), 14'h1357}, 0);
      @(posedge sys_clk);
      interfaceSelect <= 1'b1;
      apb(1'b1, `CTRL_OFS, 32'h0, r, e);
      fr(24, {6'h00, aw(MODE_DAC_LOAD, 0, 0, 5'h07), 14'h2468}, 0);
      apb(1'b1, `CTRL_OFS, 32'h1, r, e);
      rb(aw(MODE_READ_ONLY, 0, 0, 5'h06), 14'h0000);
      rb(aw(MODE_READ_ONLY, 0, 0, 5'h07), 14'h0000);
      apb(1'b0, `CTRL_OFS, 32'h0, r, e);
      chk("ctrlBack", r, 32'h1);
      $display("t_off done");
   endtask : t_off

   initial begin
      repeat (10) @(posedge sys_clk);
      arst_n <= 1'b1;
      repeat (5) @(posedge sys_clk);
      t_regs();
      t_load();
      t_all();
      t_acq();
      t_reset();
      t_off();
      report_and_stop();
   end
endmodule : multichannel_dac_serial_port_test
